// file: core/cpu_status_flag_register.v
// cpu status flag register with single-cycle alu and avalon-mm register access
//
// Behaviour
// [RULE1] global interrupt enable sits at bit 7 and gates all interrupts
// [RULE2] every interrupt source is blocked while the global enable is clear
// [RULE3] taking an interrupt clears the enable; return-from-interrupt sets it
// [RULE4] dedicated set and clear instructions change the global enable directly
// [RULE5] bit-copy flag at bit 6; bit-store copies in, bit-load copies out
// [RULE6] half-carry flag at bit 5 shows carry between nibbles
// [RULE7] sign flag at bit 4 always equals negative xor overflow
// [RULE8] overflow flag at bit 3 reports signed overflow
// [RULE9] negative flag at bit 2 set on negative result
// [RULE10] zero flag at bit 1 set on zero result
// [RULE11] carry flag at bit 0 set on carry out
// [RULE12] operands read, executed, written back and flags updated in one cycle
// [RULE13] service software may set the enable itself to allow nesting
// [RULE14] flags untouched by an instruction keep their value
`include "status_flag_map.vh"
module cpu_status_flag_register (
    input  wire        CORE_CLK_I,
    input  wire        ARST_N_I,
    input  wire [3:0]  AVS_ADDRESS_I,
    input  wire        AVS_READ_I,
    input  wire        AVS_WRITE_I,
    input  wire [31:0] AVS_WRITEDATA_I,
    input  wire [3:0]  AVS_BYTEENABLE_I,
    output reg  [31:0] AVS_READDATA_O,
    output reg         AVS_WAITREQUEST_O,
    input  wire [7:0]  IRQ_SOURCE_I,
    input  wire [7:0]  IRQ_SOURCE_EN_I,
    output reg         IRQ_REQUEST_O,
    output reg  [7:0]  FLAGS_O
);
    // flags held as bits 7..0: i t h s v n z c
    reg  [7:0] flags;
    reg  [7:0] opa;
    reg  [7:0] opb;
    reg  [2:0] bit_sel;
    reg        ack;
    reg  [7:0] next_flags;
    reg  [7:0] next_opa;
    reg        exec;
    wire [3:0] op;
    wire [7:0] res;
    wire       c_res;
    wire       h_res;
    wire       v_res;
    wire       is_logic;
    wire       is_arith;
    wire       t_bit;
    wire [7:0] loaded;
    wire       wr_lane0;

    function [7:0] with_sign;
        input [7:0] f;
        begin
            with_sign = f;
            with_sign[`SF_BIT_S] = f[`SF_BIT_N] ^ f[`SF_BIT_V]; // RULE7
        end
    endfunction

    // a write to the control register launches one instruction
    assign op       = AVS_WRITEDATA_I[3:0];
    assign wr_lane0 = AVS_BYTEENABLE_I[0];

    status_alu u_alu (
        .op_i    (op),
        .a_i     (opa),
        .b_i     (opb),
        .c_in_i  (flags[`SF_BIT_C]),
        .res_o   (res),
        .c_o     (c_res),
        .h_o     (h_res),
        .v_o     (v_res),
        .logic_o (is_logic),
        .arith_o (is_arith)
    );

    status_bit_copy u_bit (
        .reg_i    (opa),
        .sel_i    (AVS_WRITEDATA_I[10:8]),
        .t_i      (flags[`SF_BIT_T]),
        .bit_o    (t_bit),
        .loaded_o (loaded)
    );

    always @* begin
        next_flags = flags; // RULE14
        next_opa   = opa;
        exec       = AVS_WRITE_I && !ack && wr_lane0
                     && (AVS_ADDRESS_I == `SF_OFF_ALU_CTRL);
        if (AVS_WRITE_I && !ack && wr_lane0 && (AVS_ADDRESS_I == `SF_OFF_FLAGS)) begin
            next_flags = with_sign(AVS_WRITEDATA_I[7:0]); // RULE13
        end else if (exec) begin
            case (op)
                `OP_IRQ_SET: next_flags[`SF_BIT_I] = 1'b1; // RULE4
                `OP_IRQ_CLEAR: next_flags[`SF_BIT_I] = 1'b0; // RULE4
                `OP_RETURN_IRQ: next_flags[`SF_BIT_I] = 1'b1; // RULE3
                `OP_TAKE_IRQ: next_flags[`SF_BIT_I] = 1'b0; // RULE3
                `OP_BIT_STORE: next_flags[`SF_BIT_T] = t_bit; // RULE5
                `OP_BIT_LOAD: next_opa = loaded; // RULE5
                default: begin
                    next_opa = res; // RULE12
                    if (is_arith || is_logic) begin
                        next_flags[`SF_BIT_N] = res[7]; // RULE9
                        next_flags[`SF_BIT_Z] = (res == 8'h00); // RULE10
                        next_flags[`SF_BIT_V] = v_res; // RULE8
                    end
                    if (is_arith) begin
                        next_flags[`SF_BIT_H] = h_res; // RULE6
                        next_flags[`SF_BIT_C] = c_res; // RULE11
                    end
                    next_flags = with_sign(next_flags); // RULE7
                end
            endcase
        end
    end

    always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            flags             <= `SF_FLAGS_RESET;
            opa               <= 8'h00;
            opb               <= 8'h00;
            bit_sel           <= 3'h0;
            ack               <= 1'b0;
            AVS_READDATA_O    <= 32'h00000000;
            AVS_WAITREQUEST_O <= 1'b1;
            IRQ_REQUEST_O     <= 1'b0;
            FLAGS_O           <= `SF_FLAGS_RESET;
        end else begin
            // one wait state: request seen, answered on the next edge
            ack               <= (AVS_READ_I || AVS_WRITE_I) && !ack;
            AVS_WAITREQUEST_O <= !((AVS_READ_I || AVS_WRITE_I) && !ack);
            flags             <= next_flags;
            opa               <= next_opa;
            if (AVS_WRITE_I && !ack && wr_lane0 && (AVS_ADDRESS_I == `SF_OFF_ALU_B)) begin
                opb <= AVS_WRITEDATA_I[7:0];
            end
            if (AVS_WRITE_I && !ack && wr_lane0 && (AVS_ADDRESS_I == `SF_OFF_ALU_A)) begin
                opa <= AVS_WRITEDATA_I[7:0];
            end
            if (exec) begin
                bit_sel <= AVS_WRITEDATA_I[10:8];
            end
            if (AVS_READ_I && !ack) begin
                case (AVS_ADDRESS_I)
                    `SF_OFF_FLAGS: AVS_READDATA_O <= {24'h000000, flags};
                    `SF_OFF_ALU_A: AVS_READDATA_O <= {24'h000000, opa};
                    `SF_OFF_ALU_B: AVS_READDATA_O <= {24'h000000, opb};
                    `SF_OFF_ALU_CTRL: AVS_READDATA_O <= {21'h000000, bit_sel, 8'h00};
                    default: AVS_READDATA_O <= 32'h00000000;
                endcase
            end
            // gate by the stored flag so a clearing instruction takes effect one edge after the flag clears
            IRQ_REQUEST_O <= flags[`SF_BIT_I] && |(IRQ_SOURCE_I & IRQ_SOURCE_EN_I); // RULE1 RULE2
            FLAGS_O       <= next_flags;
        end
    end
endmodule

// file: core/status_alu.v
// single-cycle 8-bit alu producing result and candidate flags
`include "status_flag_map.vh"
module status_alu (
    input  wire [3:0] op_i,
    input  wire [7:0] a_i,
    input  wire [7:0] b_i,
    input  wire       c_in_i,
    output reg  [7:0] res_o,
    output reg        c_o,
    output reg        h_o,
    output reg        v_o,
    output reg        logic_o,
    output reg        arith_o
);
    reg [8:0] wide;
    reg [4:0] low;
    always @* begin
        wide    = 9'h000;
        low     = 5'h00;
        res_o   = a_i;
        c_o     = 1'b0;
        h_o     = 1'b0;
        v_o     = 1'b0;
        logic_o = 1'b0;
        arith_o = 1'b0;
        case (op_i)
            `OP_ADD, `OP_ADC: begin
                wide    = {1'b0, a_i} + {1'b0, b_i} + {8'h00, c_in_i & (op_i == `OP_ADC)};
                low     = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]}
                          + {4'h0, c_in_i & (op_i == `OP_ADC)};
                res_o   = wide[7:0];
                c_o     = wide[8];
                h_o     = low[4];
                v_o     = (a_i[7] == b_i[7]) && (wide[7] != a_i[7]);
                arith_o = 1'b1;
            end
            `OP_SUB, `OP_SBC: begin
                wide    = {1'b0, a_i} - {1'b0, b_i} - {8'h00, c_in_i & (op_i == `OP_SBC)};
                low     = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]}
                          - {4'h0, c_in_i & (op_i == `OP_SBC)};
                res_o   = wide[7:0];
                c_o     = wide[8];
                h_o     = low[4];
                v_o     = (a_i[7] != b_i[7]) && (wide[7] != a_i[7]);
                arith_o = 1'b1;
            end
            `OP_INC: begin
                res_o   = a_i + 8'h01;
                v_o     = (a_i == 8'h7f);
                logic_o = 1'b1;
            end
            `OP_AND: begin
                res_o   = a_i & b_i;
                logic_o = 1'b1;
            end
            `OP_OR: begin
                res_o   = a_i | b_i;
                logic_o = 1'b1;
            end
            `OP_XOR: begin
                res_o   = a_i ^ b_i;
                logic_o = 1'b1;
            end
            `OP_MOV: res_o = b_i;
            default: res_o = a_i;
        endcase
    end
endmodule

// file: core/status_bit_copy.v
// bit-store select and bit-load insert for the bit copy storage flag
`include "status_flag_map.vh"
module status_bit_copy (
    input  wire [7:0] reg_i,
    input  wire [2:0] sel_i,
    input  wire       t_i,
    output wire       bit_o,
    output wire [7:0] loaded_o
);
    assign bit_o    = reg_i[sel_i];
    assign loaded_o = (reg_i & ~(8'h01 << sel_i)) | ({7'h00, t_i} << sel_i);
endmodule

// file: core/status_flag_map.vh
// register offsets, flag positions, opcodes and reset values of the status flag block
`ifndef STATUS_FLAG_MAP_VH
`define STATUS_FLAG_MAP_VH
`define SF_OFF_FLAGS      4'h0
`define SF_OFF_ALU_A      4'h4
`define SF_OFF_ALU_B      4'h8
`define SF_OFF_ALU_CTRL   4'hc
`define SF_BIT_I          7
`define SF_BIT_T          3'd6
`define SF_BIT_H          5
`define SF_BIT_S          4
`define SF_BIT_V          3
`define SF_BIT_N          2
`define SF_BIT_Z          1
`define SF_BIT_C          0
`define SF_FLAGS_RESET    8'h00
`define OP_NOP            4'h0
`define OP_ADD            4'h1
`define OP_ADC            4'h2
`define OP_SUB            4'h3
`define OP_SBC            4'h4
`define OP_AND            4'h5
`define OP_OR             4'h6
`define OP_XOR            4'h7
`define OP_BIT_STORE      4'h8
`define OP_BIT_LOAD       4'h9
`define OP_IRQ_SET        4'ha
`define OP_IRQ_CLEAR      4'hb
`define OP_RETURN_IRQ     4'hc
`define OP_TAKE_IRQ       4'hd
`define OP_INC            4'he
`define OP_MOV            4'hf
`endif

// file: testbench/flag_chk.sv
// port assertions for the cpu status flag block
`include "status_flag_map.vh"
module flag_chk (
    input wire        CORE_CLK_I,
    input wire        ARST_N_I,
    input wire [3:0]  AVS_ADDRESS_I,
    input wire        AVS_WRITE_I,
    input wire [31:0] AVS_WRITEDATA_I,
    input wire [3:0]  AVS_BYTEENABLE_I,
    input wire        AVS_WAITREQUEST_O,
    input wire [7:0]  IRQ_SOURCE_I,
    input wire [7:0]  IRQ_SOURCE_EN_I,
    input wire        IRQ_REQUEST_O,
    input wire [7:0]  FLAGS_O
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [3:0] op = AVS_WRITEDATA_I[3:0];
    wire       go = AVS_WRITE_I && AVS_WAITREQUEST_O && AVS_ADDRESS_I == 4'hc && AVS_BYTEENABLE_I[0];
    reg        want;
    always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) want <= 1'b0;
        else want <= FLAGS_O[7] && |(IRQ_SOURCE_I & IRQ_SOURCE_EN_I);
    end
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    sign_xor_a: assert property (FLAGS_O[4] == (FLAGS_O[2] ^ FLAGS_O[3]))
        else $error("sign flag");
    irq_gate_a: assert property (IRQ_REQUEST_O == want) else $error("irq gate");
    take_clr_a: assert property (go && op == `OP_TAKE_IRQ |=> !FLAGS_O[7]) else $error("take");
    return_from_irq_op_set_a: assert property (go && op == `OP_RETURN_IRQ |=> FLAGS_O[7]) else $error("ret");
    sei_set_a: assert property (go && op == `OP_IRQ_SET |=> FLAGS_O[7]) else $error("set");
    cli_clr_a: assert property (go && op == `OP_IRQ_CLEAR |=> !FLAGS_O[7]) else $error("clr");
    nop_keep_a: assert property (go && op == `OP_NOP |=> $stable(FLAGS_O)) else $error("nop");
    logic_v_a: assert property (go && op == `OP_AND |=> !FLAGS_O[3] && $stable(FLAGS_O[0]))
        else $error("logic flags");
    one_wait_a: assert property (go |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
        else $error("wait state");
    cover property (go && op == `OP_TAKE_IRQ);
    cover property (IRQ_REQUEST_O);
    cover property (go && op == `OP_BIT_LOAD);
endmodule
bind cpu_status_flag_register flag_chk i_chk (.CORE_CLK_I(CORE_CLK_I), .ARST_N_I(ARST_N_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .IRQ_SOURCE_I(IRQ_SOURCE_I), .IRQ_SOURCE_EN_I(IRQ_SOURCE_EN_I),
    .IRQ_REQUEST_O(IRQ_REQUEST_O), .FLAGS_O(FLAGS_O));

// file: testbench/irq_src_model.sv
// interrupt source model: random request levels and per-source enables
module irq_src_model (
    input  wire       clk_i,
    output reg  [7:0] src_o = 8'h00,
    output reg  [7:0] en_o = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    integer seed = 32'h5a3c;
    // new mix every cycle so the global gate meets all enable patterns
    always @(posedge clk_i) begin
        src_o <= $random(seed);
        en_o <= $random(seed);
    end
endmodule

// file: testbench/tb.sv
// self-checking bench: bus-driven alu ops against a reference flag model
`include "status_flag_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg         clk = 1'b0;
    reg         arst_n = 1'b0;
    reg  [3:0]  addr = 4'h0;
    reg         rd = 1'b0;
    reg         wr = 1'b0;
    reg  [31:0] wdata = 32'h0;
    reg  [3:0]  be = 4'hf;
    reg  [7:0]  f;
    reg  [31:0] q;
    wire [31:0] rdata;
    wire        wreq;
    wire [7:0]  src;
    wire [7:0]  en;
    wire [7:0]  flags;
    integer     num_errors = 0, n_checks = 0, seed = 32'hc4b8, cyc = 0, i;
    cpu_status_flag_register i_dut (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .IRQ_SOURCE_I(src),
        .IRQ_SOURCE_EN_I(en), .IRQ_REQUEST_O(), .FLAGS_O(flags));
    irq_src_model i_src (.clk_i(clk), .src_o(src), .en_o(en));
    initial forever #12.5 clk = ~clk;
    task results;
        if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            results;
        end
    end
    task cmp(input string name, input [31:0] exp, input [31:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // request held until waitrequest is sampled low, then released for one cycle
    task bus(input [3:0] a, input w, input [31:0] d);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task op_chk(input [3:0] op);
        reg [7:0] a, b;
        reg [8:0] s;
        reg [2:0] sel;
        integer   cin;
        a = $random(seed);
        b = $random(seed);
        sel = $random(seed);
        f = $random(seed);
        bus(`SF_OFF_FLAGS, 1, f);
        f[4] = f[2] ^ f[3];
        bus(`SF_OFF_ALU_A, 1, a);
        bus(`SF_OFF_ALU_B, 1, b);
        bus(`SF_OFF_ALU_CTRL, 1, {21'h0, sel, 4'h0, op});
        cin = (op == 2 || op == 4) ? f[0] : 0;
        s = a;
        case (op)
            1, 2: begin
                s = a + b + cin;
                f[5] = a[3:0] + b[3:0] + cin > 15;
                f[3] = a[7] == b[7] && s[7] != a[7];
                f[0] = s[8];
            end
            3, 4: begin
                s = a - b - cin;
                f[5] = a[3:0] < b[3:0] + cin;
                f[3] = a[7] != b[7] && s[7] != a[7];
                f[0] = s[8];
            end
            5, 6, 7: begin
                s = op == 5 ? a & b : op == 6 ? a | b : a ^ b;
                f[3] = 1'b0;
            end
            8: f[6] = a[sel];
            10, 12: f[7] = 1'b1;
            11, 13: f[7] = 1'b0;
            14: begin
                s = a + 1;
                f[3] = a == 8'h7f;
            end
            15: s = b;
            default: s = a;
        endcase
        if (op == 9) s[sel] = f[6];
        if (op >= 1 && op <= 7 || op == 14) begin
            f[2] = s[7];
            f[1] = s[7:0] == 0;
            f[4] = f[2] ^ f[3];
        end
        bus(`SF_OFF_FLAGS, 0, 0);
        cmp("flags", {24'h0, f}, q);
        cmp("flags_port", {24'h0, f}, {24'h0, flags});
        bus(`SF_OFF_ALU_A, 0, 0);
        cmp("result", {24'h0, s[7:0]}, q);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        bus(`SF_OFF_FLAGS, 0, 0);
        cmp("flags_reset", {24'h0, `SF_FLAGS_RESET}, q);
        bus(4'h2, 1, 32'hff);
        bus(4'h2, 0, 0);
        cmp("unmapped", 0, q);
        be <= 4'he;
        bus(`SF_OFF_FLAGS, 1, 32'hff);
        be <= 4'hf;
        bus(`SF_OFF_FLAGS, 0, 0);
        cmp("lane_off", 0, q);
        // every opcode six times; irq set after take covers nesting
        for (i = 0; i < 96; i = i + 1) op_chk(i[3:0]);
        results;
    end
endmodule
